// ===== logic/rss_pkg.sv
// Purpose: Constants and types for the reset source and status block
// Assumes: 25 MHz core clock, 8-bit register port, 21-bit program counter
// Notes:   Offsets are word indices on the plain register port

package rss_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_STACK  = 4'h1;
  localparam logic [3:0] ADDR_CTRL   = 4'h2;

  // Status register bits, active-low cause flags
  localparam int BIT_BROWNOUT = 0;
  localparam int BIT_POWERON  = 1;
  localparam int BIT_PWRDN    = 2;
  localparam int BIT_TIMEOUT  = 3;
  localparam int BIT_RSTINSTR = 4;
  localparam logic [7:0] STATUS_MASK    = 8'h1f;
  localparam logic [7:0] STATUS_POR_VAL = 8'h1c;

  // Stack error register bits
  localparam int BIT_STK_FULL  = 7;
  localparam int BIT_STK_UNDER = 6;
  localparam logic [7:0] STACK_MASK    = 8'hc0;
  localparam logic [7:0] STACK_POR_VAL = 8'h00;

  // Control register bits
  localparam int BIT_EXT_EN = 0;
  localparam int BIT_STK_EN = 1;
  localparam logic [7:0] CTRL_MASK    = 8'h03;
  localparam logic [7:0] CTRL_POR_VAL = 8'h03;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int FILTER_NS     = 200;
  localparam int HOLD_NS       = 400;
  localparam int FILTER_CYC =
    (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC =
    (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] FILTER_LAST = 3'(FILTER_CYC - 1);
  localparam logic [3:0] HOLD_LAST   = 4'(HOLD_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // Program counter values
  localparam int PC_W = 21;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] VEC_HIGH = 21'h000008;
  localparam logic [20:0] VEC_LOW  = 21'h000018;
  localparam logic [20:0] PC_STEP  = 21'h000002;

  typedef enum logic [1:0] {
    MODE_FULL  = 2'b00,
    MODE_RUN   = 2'b01,
    MODE_IDLE  = 2'b10,
    MODE_SLEEP = 2'b11
  } rss_mode_e;

  typedef enum logic {
    ST_RUN  = 1'b0,
    ST_HOLD = 1'b1
  } rss_state_e;

endpackage

// ===== logic/rss_reset_source_status.sv
// Purpose: Combine reset sources, hold core reset, record reset causes
// Assumes: Core-side strobes are one-cycle pulses on CORE_CLK
// Notes:   RSTN is the power-up detector output; it alone loads the flag reset values
//
// Behaviour
// - Low external pin holds device in reset
// - Filter ignores short low pin pulses
// - Device never drives the reset pin low
// - Disabled pin is plain digital input only
// - Power-up detector starts a reset pulse
// - Power-on flag cleared only by power-on
// - Only software sets power-on flag again
// - Power-on and brown-out flag patterns, restart zero
// - Reset instruction clears its flag, restarts zero
// - Pin reset in run mode sets timeout
// - Pin reset in idle/sleep: timeout set, powerdown cleared
// - Pin reset at full power changes nothing
// - Watchdog at full/run resets, clears timeout
// - Watchdog in idle/sleep resumes PC plus two
// - Enabled stack overflow resets, sets full flag
// - Enabled stack underflow resets, sets underflow flag
// - Disabled underflow sets flag without reset
// - Interrupt wake clears powerdown, resumes PC plus two
// - Wake with interrupt enables loads vector
// - Control state kept through non-power-on resets

`timescale 1ns/1ps

module rss_reset_source_status (
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic        EXT_RESET_PIN_N,
  input  wire logic        BROWNOUT_DET,
  input  wire logic [1:0]  PWR_MODE,
  input  wire logic        WATCHDOG_TIMEOUT,
  input  wire logic        RESET_INSTR,
  input  wire logic        STACK_OVERFLOW,
  input  wire logic        STACK_UNDERFLOW,
  input  wire logic        INT_WAKE,
  input  wire logic        GLOBAL_INT_ENABLE_HIGH,
  input  wire logic        GLOBAL_INT_ENABLE_LOW,
  input  wire logic [20:0] PC_CURRENT,
  input  wire logic [3:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  output logic             CORE_RESET_N,
  output logic             RESTART_LOAD,
  output logic      [20:0] RESTART_PC,
  output logic             PIN_DIGITAL_IN,
  output logic             EXT_PIN_OUT,
  output logic             EXT_PIN_OE
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                  pin_meta;
  logic                  pin_sync;
  logic                  bo_meta;
  logic                  bo_lvl;
  logic                  bo_lvl_q;
  logic                  ext_lvl_q;
  logic [2:0]            flt_cnt;
  logic                  flt_low;
  logic                  ext_lvl;
  logic                  ext_rise;
  logic                  bo_rise;
  logic                  hold_lvl;
  logic [7:0]            reset_control_status_reg;
  logic [7:0]            stack_flags;
  logic [7:0]            ctrl_reg;
  logic [7:0]            next_status;
  logic [7:0]            next_stack;
  logic                  ext_reset_pin_enable_cfg;
  logic                  stack_error_reset_enable;
  logic                  wr_status;
  logic                  wr_stack;
  logic                  wr_ctrl;
  logic                  run_st;
  logic                  halt;
  logic                  dog_evt;
  logic                  instr_evt;
  logic                  ovf_evt;
  logic                  unf_evt;
  logic                  wake_evt;
  logic                  reset_evt;
  logic                  resume_evt;
  logic                  release_ok;
  logic [3:0]            hold_cnt;
  rss_pkg::rss_state_e   state;
  logic                  brownout_flag_n;
  logic                  power_on_flag_n;
  logic                  power_down_flag_n;
  logic                  timeout_flag_n;
  logic                  reset_instr_flag_n;
  logic                  stack_full_flag;
  logic                  stack_underflow_flag;

  function automatic logic is_halt(input logic [1:0] mode);
    is_halt = (mode == rss_pkg::MODE_IDLE) ||
              (mode == rss_pkg::MODE_SLEEP);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin and detector synchronisers
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      bo_meta  <= 1'b0;
      bo_lvl   <= 1'b0;
    end else begin
      pin_meta <= EXT_RESET_PIN_N;
      pin_sync <= pin_meta;
      bo_meta  <= BROWNOUT_DET;
      bo_lvl   <= bo_meta;
    end
  end

  // Glitch filter: low must persist FILTER_CYC samples
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      flt_cnt <= 3'h0;
      flt_low <= 1'b0;
    end else if (pin_sync) begin
      flt_cnt <= 3'h0;
      flt_low <= 1'b0;
    end else if (flt_cnt == rss_pkg::FILTER_LAST) begin
      flt_low <= 1'b1;
    end else begin
      flt_cnt <= flt_cnt + 3'h1;
    end
  end

  assign ext_lvl  = flt_low & ext_reset_pin_enable_cfg;
  assign hold_lvl = ext_lvl | bo_lvl;
  assign ext_rise = ext_lvl & ~ext_lvl_q;
  assign bo_rise  = bo_lvl & ~bo_lvl_q;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ext_lvl_q <= 1'b0;
      bo_lvl_q  <= 1'b0;
    end else begin
      ext_lvl_q <= ext_lvl;
      bo_lvl_q  <= bo_lvl;
    end
  end

  // Pin as digital input when reset use is off
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PIN_DIGITAL_IN <= 1'b1;
    end else begin
      PIN_DIGITAL_IN <= ext_reset_pin_enable_cfg ? 1'b1 : pin_sync;
    end
  end

  // Input only: the pin is never driven
  assign EXT_PIN_OUT = 1'b0;
  assign EXT_PIN_OE  = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Core events, only seen while the core runs
  assign run_st    = (state == rss_pkg::ST_RUN);
  assign halt      = is_halt(PWR_MODE);
  assign dog_evt   = run_st & WATCHDOG_TIMEOUT;
  assign instr_evt = run_st & RESET_INSTR;
  assign ovf_evt   = run_st & STACK_OVERFLOW;
  assign unf_evt   = run_st & STACK_UNDERFLOW;
  assign wake_evt  = run_st & INT_WAKE & halt;

  assign reset_evt = ext_rise | bo_rise | instr_evt |
                     (dog_evt & ~halt) |
                     (stack_error_reset_enable &
                      (ovf_evt | unf_evt));
  assign resume_evt = ~reset_evt & (dog_evt | wake_evt) & halt;
  assign release_ok = (state == rss_pkg::ST_HOLD) && !hold_lvl &&
                      !reset_evt && (hold_cnt == 4'h0);

  ////////////////////////////////////////////////////////////////////////
  // Reset hold sequencer; power-up starts in hold
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state        <= rss_pkg::ST_HOLD;
      hold_cnt     <= rss_pkg::HOLD_LAST;
      CORE_RESET_N <= 1'b0;
    end else begin
      unique case (state)
        rss_pkg::ST_RUN: begin
          if (reset_evt || hold_lvl) begin
            state        <= rss_pkg::ST_HOLD;
            hold_cnt     <= rss_pkg::HOLD_LAST;
            CORE_RESET_N <= 1'b0;
          end
        end
        rss_pkg::ST_HOLD: begin
          if (hold_lvl || reset_evt) begin
            hold_cnt <= rss_pkg::HOLD_LAST;
          end else if (hold_cnt == 4'h0) begin
            state        <= rss_pkg::ST_RUN;
            CORE_RESET_N <= 1'b1;
          end else begin
            hold_cnt <= hold_cnt - 4'h1;
          end
        end
      endcase
    end
  end

  // Restart address, one pulse per restart or resume
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RESTART_LOAD <= 1'b0;
      RESTART_PC   <= rss_pkg::PC_RESET;
    end else if (release_ok) begin
      RESTART_LOAD <= 1'b1;
      RESTART_PC   <= rss_pkg::PC_RESET;
    end else if (resume_evt) begin
      RESTART_LOAD <= 1'b1;
      if (dog_evt) begin
        RESTART_PC <= PC_CURRENT + rss_pkg::PC_STEP;
      end else if (GLOBAL_INT_ENABLE_HIGH) begin
        RESTART_PC <= rss_pkg::VEC_HIGH;
      end else if (GLOBAL_INT_ENABLE_LOW) begin
        RESTART_PC <= rss_pkg::VEC_LOW;
      end else begin
        RESTART_PC <= PC_CURRENT + rss_pkg::PC_STEP;
      end
    end else begin
      RESTART_LOAD <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cause flags; hardware effects follow the write so hardware wins
  assign wr_status = WR && (ADDR == rss_pkg::ADDR_STATUS);
  assign wr_stack  = WR && (ADDR == rss_pkg::ADDR_STACK);
  assign wr_ctrl   = WR && (ADDR == rss_pkg::ADDR_CTRL);

  always_comb begin
    next_status = reset_control_status_reg;
    next_stack  = stack_flags;
    if (wr_status) begin
      next_status = WDATA & rss_pkg::STATUS_MASK;
    end
    if (wr_stack) begin
      next_stack = WDATA & rss_pkg::STACK_MASK;
    end
    if (dog_evt) begin
      next_status[rss_pkg::BIT_TIMEOUT] = 1'b0;
      if (halt) begin
        next_status[rss_pkg::BIT_PWRDN] = 1'b0;
      end
    end
    if (wake_evt) begin
      next_status[rss_pkg::BIT_PWRDN] = 1'b0;
    end
    if (instr_evt) begin
      next_status[rss_pkg::BIT_RSTINSTR] = 1'b0;
    end
    if (ovf_evt) begin
      next_stack[rss_pkg::BIT_STK_FULL] = 1'b1;
    end
    if (unf_evt) begin
      next_stack[rss_pkg::BIT_STK_UNDER] = 1'b1;
    end
    if (ext_rise && (PWR_MODE != rss_pkg::MODE_FULL)) begin
      next_status[rss_pkg::BIT_TIMEOUT] = 1'b1;
      if (halt) begin
        next_status[rss_pkg::BIT_PWRDN] = 1'b0;
      end
    end
    if (bo_rise) begin
      next_status[rss_pkg::BIT_RSTINSTR] = 1'b1;
      next_status[rss_pkg::BIT_TIMEOUT]  = 1'b1;
      next_status[rss_pkg::BIT_PWRDN]    = 1'b1;
      next_status[rss_pkg::BIT_BROWNOUT] = 1'b0;
    end
  end

  // Only power-up reloads these; internal resets change only their cause flags
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      reset_control_status_reg <= rss_pkg::STATUS_POR_VAL;
      stack_flags              <= rss_pkg::STACK_POR_VAL;
    end else begin
      reset_control_status_reg <= next_status;
      stack_flags              <= next_stack;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_reg <= rss_pkg::CTRL_POR_VAL;
    end else if (wr_ctrl) begin
      ctrl_reg <= WDATA & rss_pkg::CTRL_MASK;
    end
  end

  assign ext_reset_pin_enable_cfg = ctrl_reg[rss_pkg::BIT_EXT_EN];
  assign stack_error_reset_enable = ctrl_reg[rss_pkg::BIT_STK_EN];

  // Read data valid the cycle after the read strobe only
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      unique case (ADDR)
        rss_pkg::ADDR_STATUS: RDATA <= reset_control_status_reg;
        rss_pkg::ADDR_STACK:  RDATA <= stack_flags;
        rss_pkg::ADDR_CTRL:   RDATA <= ctrl_reg;
        default:              RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  assign brownout_flag_n    = reset_control_status_reg[0];
  assign power_on_flag_n    = reset_control_status_reg[1];
  assign power_down_flag_n  = reset_control_status_reg[2];
  assign timeout_flag_n     = reset_control_status_reg[3];
  assign reset_instr_flag_n = reset_control_status_reg[4];
  assign stack_full_flag      = stack_flags[rss_pkg::BIT_STK_FULL];
  assign stack_underflow_flag = stack_flags[rss_pkg::BIT_STK_UNDER];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  pin_hold_a: assert property (
    ext_lvl |=> !CORE_RESET_N
  ) else $error("core left reset while pin held low");

  glitch_reject_a: assert property (
    pin_sync ##1 !pin_sync [*4] |=> !flt_low
  ) else $error("short pin pulse reached reset");

  pin_undriven_a: assert property (
    !CORE_RESET_N |-> !EXT_PIN_OE && !EXT_PIN_OUT
  ) else $error("reset pin driven by device");

  pin_disabled_a: assert property (
    !ext_reset_pin_enable_cfg |-> !ext_lvl ##1
      PIN_DIGITAL_IN == $past(pin_sync)
  ) else $error("disabled pin acted as reset");

  poweron_set_a: assert property (
    $rose(power_on_flag_n) |->
      $past(wr_status) && $past(WDATA[1])
  ) else $error("power-on flag set by hardware");

  brownout_flags_a: assert property (
    bo_rise |=> !brownout_flag_n && timeout_flag_n &&
      power_down_flag_n && reset_instr_flag_n && !CORE_RESET_N
  ) else $error("brown-out flag pattern wrong");

  instr_flag_a: assert property (
    instr_evt && !bo_rise |=> !reset_instr_flag_n && !CORE_RESET_N
  ) else $error("reset instruction not recorded");

  dog_run_a: assert property (
    dog_evt && !halt && !ext_rise && !bo_rise |=>
      !timeout_flag_n && !CORE_RESET_N
  ) else $error("watchdog reset not taken");

  dog_resume_a: assert property (
    dog_evt && halt && !reset_evt |=> CORE_RESET_N && RESTART_LOAD &&
      RESTART_PC == $past(PC_CURRENT) + rss_pkg::PC_STEP &&
      !timeout_flag_n && !power_down_flag_n
  ) else $error("watchdog wake resume wrong");

  underflow_soft_a: assert property (
    unf_evt && !stack_error_reset_enable && !reset_evt |=>
      stack_underflow_flag && CORE_RESET_N
  ) else $error("soft underflow reset or lost");

  wake_vector_a: assert property (
    wake_evt && !dog_evt && !reset_evt && GLOBAL_INT_ENABLE_HIGH |=>
      RESTART_LOAD && RESTART_PC == rss_pkg::VEC_HIGH
  ) else $error("high vector not loaded on wake");

  release_zero_a: assert property (
    $rose(CORE_RESET_N) |-> RESTART_LOAD &&
      RESTART_PC == rss_pkg::PC_RESET && $past(!hold_lvl, 1)
  ) else $error("release without zero restart");

  pin_reset_c: cover property (
    ext_rise ##[1:40] $rose(CORE_RESET_N)
  );

  dog_wake_c: cover property (dog_evt && halt && !reset_evt);

  int_vector_c: cover property (
    wake_evt && GLOBAL_INT_ENABLE_LOW && !GLOBAL_INT_ENABLE_HIGH
  );

  underflow_c: cover property (unf_evt && !stack_error_reset_enable);

endmodule // rss_reset_source_status

// ===== testbench/rss_reset_switch.sv
// Purpose: Reset switch model on the external reset pin
// Assumes: Pin has a pull-up; the switch can only pull it low
// Notes:   Glitch mode gives short low pulses for filter tests

`timescale 1ns/1ps

module rss_reset_switch (
  input  wire logic       clk,
  input  wire logic       press,
  input  wire logic [3:0] glitch_cyc,
  input  wire logic       glitch_go,
  output logic            pin_n
);

  logic [3:0] left = 4'h0;

  always @(posedge clk) begin
    if (glitch_go) begin
      left <= glitch_cyc;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end

  // Released pin rises through the pull-up, never left floating
  assign pin_n = !(press || (left != 4'h0));

endmodule // rss_reset_switch

// ===== testbench/test_reset_source_status.sv
// Purpose: Self-checking bench for the reset source and status block
// Assumes: 25 MHz clock, register port with read data one cycle later
// Notes:   Table rows cover core events; pin, brown-out, power-up by hand

`timescale 1ns/1ps

module test_reset_source_status;

  typedef struct packed {
    logic [1:0]  mode;
    logic [2:0]  ev;
    logic        stk;
    logic [1:0]  gie;
    logic [20:0] pc;
    logic        rst;
    logic        load;
    logic [20:0] npc;
    logic [7:0]  st;
    logic [7:0]  sk;
  } rss_row_s;

  // Events: 0 watchdog, 1 reset instr, 2 overflow, 3 underflow, 4 wake
  rss_row_s    rows [12] = '{
    '{2'h0,3'h0,1'h1,2'h0,21'h100,1'h1,1'h1,21'h0,8'h17,8'h0},
    '{2'h1,3'h0,1'h1,2'h0,21'h100,1'h1,1'h1,21'h0,8'h17,8'h0},
    '{2'h3,3'h0,1'h1,2'h0,21'h100,1'h0,1'h1,21'h102,8'h13,8'h0},
    '{2'h2,3'h0,1'h1,2'h0,21'hffffe,1'h0,1'h1,21'h100000,8'h13,8'h0},
    '{2'h0,3'h1,1'h1,2'h0,21'h100,1'h1,1'h1,21'h0,8'h0f,8'h0},
    '{2'h0,3'h2,1'h1,2'h0,21'h100,1'h1,1'h1,21'h0,8'h1f,8'h80},
    '{2'h0,3'h3,1'h1,2'h0,21'h100,1'h1,1'h1,21'h0,8'h1f,8'h40},
    '{2'h0,3'h3,1'h0,2'h0,21'h100,1'h0,1'h0,21'h0,8'h1f,8'h40},
    '{2'h3,3'h4,1'h1,2'h0,21'h200,1'h0,1'h1,21'h202,8'h1b,8'h0},
    '{2'h2,3'h4,1'h1,2'h2,21'h200,1'h0,1'h1,21'h008,8'h1b,8'h0},
    '{2'h3,3'h4,1'h1,2'h1,21'h200,1'h0,1'h1,21'h018,8'h1b,8'h0},
    '{2'h0,3'h4,1'h1,2'h3,21'h200,1'h0,1'h0,21'h0,8'h1f,8'h0}
  };
  logic [7:0]  pin_exp [4] = '{8'h17, 8'h1f, 8'h1b, 8'h1b};
  rss_row_s    r;
  int          n_errors = 0;
  int          compares = 0;
  logic        clk, rstn, pin_n, bod, wdog, rinst, sov, sun, iwake;
  logic        int_en_hi, int_en_lo, wr, rd, press, ggo;
  logic        core_rst_n, rload, pin_din, pin_out, pin_oe;
  logic [1:0]  mode;
  logic [3:0]  addr, gcyc;
  logic [7:0]  wdata, rdata;
  logic [20:0] pc, rpc;

  rss_reset_source_status rss_reset_source_status_inst (
    .CORE_CLK               (clk),
    .RSTN                   (rstn),
    .EXT_RESET_PIN_N        (pin_n),
    .BROWNOUT_DET           (bod),
    .PWR_MODE               (mode),
    .WATCHDOG_TIMEOUT       (wdog),
    .RESET_INSTR            (rinst),
    .STACK_OVERFLOW         (sov),
    .STACK_UNDERFLOW        (sun),
    .INT_WAKE               (iwake),
    .GLOBAL_INT_ENABLE_HIGH (int_en_hi),
    .GLOBAL_INT_ENABLE_LOW  (int_en_lo),
    .PC_CURRENT             (pc),
    .ADDR                   (addr),
    .WDATA                  (wdata),
    .WR                     (wr),
    .RD                     (rd),
    .RDATA                  (rdata),
    .CORE_RESET_N           (core_rst_n),
    .RESTART_LOAD           (rload),
    .RESTART_PC             (rpc),
    .PIN_DIGITAL_IN         (pin_din),
    .EXT_PIN_OUT            (pin_out),
    .EXT_PIN_OE             (pin_oe)
  );

  rss_reset_switch rss_reset_switch_inst (
    .clk        (clk),
    .press      (press),
    .glitch_cyc (gcyc),
    .glitch_go  (ggo),
    .pin_n      (pin_n)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [20:0] got, input logic [20:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h",
               $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk(21'(rdata), 21'(e), "read data");
  endtask

  // Bounded waits, called at a falling edge
  task automatic wait_low();
    for (int n = 0; n < 20 && core_rst_n !== 1'b0; n++) @(negedge clk);
    chk(21'(core_rst_n), 21'h0, "core reset entered");
  endtask

  task automatic wait_load();
    for (int n = 0; n < 40 && rload !== 1'b1; n++) @(negedge clk);
    chk(21'(rload), 21'h1, "restart load");
    chk(21'(core_rst_n), 21'h1, "core released with load");
    chk(rpc, 21'h0, "restart at zero");
  endtask

  task automatic por();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (16) @(posedge clk);
    chk(21'(core_rst_n), 21'h0, "held in power-up");
    rstn <= 1'b1;
    @(negedge clk);
    wait_load();
    rd_chk(4'h0, 8'h1c);
    rd_chk(4'h1, 8'h00);
    rd_chk(4'h2, 8'h03);
  endtask

  task automatic glitch(input logic [3:0] n);
    @(posedge clk);
    gcyc <= n;
    ggo  <= 1'b1;
    @(posedge clk);
    ggo  <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Whole run is under a thousand cycles; the 10000-cycle limit allows ample slack
  initial begin
    #400000;
    n_errors++;
    wrap_up();
  end

  initial begin
    {rstn, bod, wdog, rinst, sov, sun, iwake, int_en_hi, int_en_lo} = 9'h0;
    {wr, rd, press, ggo, mode, addr, gcyc, wdata, pc} = 0;
    por();
    wr_reg(4'h0, 8'hff);
    rd_chk(4'h0, 8'h1f);
    foreach (rows[i]) begin
      r = rows[i];
      wr_reg(4'h2, {6'h0, r.stk, 1'b1});
      wr_reg(4'h0, 8'h1f);
      wr_reg(4'h1, 8'h00);
      @(posedge clk);
      mode <= r.mode;
      {int_en_hi, int_en_lo} <= r.gie;
      pc <= r.pc;
      @(posedge clk);
      {iwake, sun, sov, rinst, wdog} <= 5'h1 << r.ev;
      @(posedge clk);
      {iwake, sun, sov, rinst, wdog} <= 5'h0;
      @(negedge clk);
      chk(21'(!core_rst_n), 21'(r.rst), "reset taken");
      chk(21'(rload), 21'(r.load && !r.rst), "resume");
      if (r.rst) wait_load();
      if (r.load) chk(rpc, r.npc, "restart pc");
      rd_chk(4'h0, r.st);
      rd_chk(4'h1, r.sk);
    end
    wr_reg(4'h5, 8'hff);
    rd_chk(4'h5, 8'h00);
    wr_reg(4'h1, 8'hff);
    rd_chk(4'h1, 8'hc0);
    @(posedge clk);
    mode <= 2'h0;
    glitch(4'h4);
    repeat (20) @(negedge clk);
    chk(21'(core_rst_n), 21'h1, "short glitch ignored");
    glitch(4'h5);
    @(negedge clk);
    wait_low();
    wait_load();
    for (int m = 0; m < 4; m++) begin
      wr_reg(4'h0, 8'h17);
      @(posedge clk);
      mode  <= 2'(m);
      press <= 1'b1;
      @(negedge clk);
      wait_low();
      repeat (20) @(negedge clk);
      chk(21'(core_rst_n), 21'h0, "held by pin");
      chk(21'({pin_oe, pin_out}), 21'h0, "pin not driven");
      @(posedge clk);
      press <= 1'b0;
      @(negedge clk);
      wait_load();
      rd_chk(4'h0, pin_exp[m]);
    end
    wr_reg(4'h2, 8'h02);
    @(posedge clk);
    press <= 1'b1;
    repeat (20) @(negedge clk);
    chk(21'(core_rst_n), 21'h1, "disabled pin ignored");
    chk(21'(pin_din), 21'h0, "pin read as input");
    @(posedge clk);
    press <= 1'b0;
    repeat (6) @(negedge clk);
    chk(21'(pin_din), 21'h1, "pin input high");
    wr_reg(4'h2, 8'h03);
    wr_reg(4'h0, 8'h03);
    @(posedge clk);
    bod <= 1'b1;
    @(negedge clk);
    wait_low();
    @(posedge clk);
    bod <= 1'b0;
    @(negedge clk);
    wait_load();
    rd_chk(4'h0, 8'h1e);
    rd_chk(4'h1, 8'hc0);
    wr_reg(4'h0, 8'h1f);
    wr_reg(4'h2, 8'h00);
    por();
    wrap_up();
  end

endmodule // test_reset_source_status
